//--- design/ebt_exec_timing.sv
// Execution unit sequencer with the bus control unit arbiter.
// Assumes the opcode source holds OP_VALID and its fields until OP_ACCEPT,
// and the bus ends every started cycle with a BUS_DONE pulse.
// Function
// - Stall while opcode queue is empty
// - Branch flushes queue, stall until refilled
// - Off-main read waits for bus cycle start
// - Posted write lets execution continue at once
// - Pending write blocks off-main and branch, not register ops
// - Fetch outranks pending external or peripheral writes
// - Fetch in progress delays data or branch
// - Dual-port window fast, other internal RAM slower
// - Each external access adds wait count
// - Shifts add one clock per bit
// - Stack ops scale with register count
// - String ops scale with iteration count
// - Standby/watchdog byte store decoded separately
// - Clock count excludes queue refill time
// - Some variants use normal-fetch timing only
module ebt_exec_timing #(
    parameter bit NORMAL_FETCH_ONLY = 1'b0
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CE,
    input wire logic OP_VALID,
    input wire ebt_pkg::ebt_kind_t OP_KIND,
    input wire logic [15:0] OP_ADDR,
    input wire logic [7:0] OP_BASE,
    input wire logic [7:0] OP_N,
    input wire logic [1:0] OP_EXT_ACCESSES,
    input wire logic [2:0] OP_LEN,
    input wire logic [1:0] OP_SFR_TARGET,
    input wire logic [3:0] WAIT_COUNT,
    input wire logic HS_FETCH,
    input wire logic QUEUE_EMPTY,
    input wire logic QUEUE_WANTS,
    input wire logic [15:0] FETCH_ADDR,
    input wire logic BUS_DONE,
    output logic OP_ACCEPT,
    output logic EXU_STALL,
    output logic QUEUE_FLUSH,
    output logic EXEC_DONE,
    output logic [15:0] CLK_COUNT,
    output logic [2:0] INSTR_LEN,
    output logic BUS_FETCH,
    output logic BUS_READ,
    output logic BUS_WRITE,
    output logic [15:0] BUS_ADDR,
    output logic WRITE_PENDING,
    output ebt_pkg::ebt_region_t ACCESS_REGION
);

    // ***********************************************************
    // State
    // ***********************************************************
    typedef struct packed {
        ebt_pkg::ebt_exu_t execution_unit;
        ebt_pkg::ebt_bcu_t bus_control_unit;
        ebt_pkg::ebt_kind_t kind;
        ebt_pkg::ebt_region_t region;
        logic [15:0] op_addr;
        logic [15:0] cnt;
        logic [15:0] clk_count;
        logic [2:0] len;
        logic refilled;
        logic stall;
        logic accept;
        logic flush;
        logic done;
        logic bcu_wr;
        logic bus_fetch;
        logic bus_read;
        logic bus_write;
        logic [15:0] bus_addr;
        logic wr_pend;
        logic [15:0] wr_addr;
    } ebt_state_t;

    ebt_state_t s;
    ebt_state_t next_s;
    ebt_pkg::ebt_region_t rg;
    logic hs;
    logic sp_target;
    logic is_mem;
    logic off_main;
    logic grant;
    logic [15:0] count;
    logic [15:0] nterm;
    logic [15:0] extra;

    ebt_region u_region (
        .addr(OP_ADDR),
        .region(rg)
    );

    // ***********************************************************
    // Instruction clock count
    // ***********************************************************
    always_comb begin
        hs = HS_FETCH && !NORMAL_FETCH_ONLY;
        sp_target = (OP_KIND == ebt_pkg::K_SPECIAL) && (OP_SFR_TARGET != 2'h0);
        is_mem = (OP_KIND == ebt_pkg::K_READ) || (OP_KIND == ebt_pkg::K_WRITE) ||
                 ((OP_KIND == ebt_pkg::K_SPECIAL) && !sp_target);
        // Stack and string operands sit in main RAM, so they stay local
        off_main = is_mem && (rg != ebt_pkg::RG_FAST);
        unique case (OP_KIND)
            ebt_pkg::K_SHIFT: nterm = {8'h00, OP_N} * ebt_pkg::SHIFT_PER_BIT;
            ebt_pkg::K_STACK: nterm = {8'h00, OP_N} * ebt_pkg::STACK_PER_REG;
            ebt_pkg::K_STRING: nterm = {8'h00, OP_N} * ebt_pkg::STRING_PER_ITER;
            default: nterm = 16'h0000;
        endcase
        extra = 16'h0000;
        if (is_mem && rg == ebt_pkg::RG_PERI) begin
            extra = hs ? ebt_pkg::PERI_EXTRA_HS : ebt_pkg::PERI_EXTRA_NF;
        end else if (is_mem && rg == ebt_pkg::RG_EXT) begin
            // One wait count per external access
            extra = (hs ? ebt_pkg::EXT_EXTRA_HS : ebt_pkg::EXT_EXTRA_NF) +
                    ({12'h000, WAIT_COUNT} * {14'h0000, OP_EXT_ACCESSES});
        end
        // Queue refill is never folded in here
        count = {8'h00, OP_BASE} + nterm + extra;
        if (sp_target) begin
            count = ebt_pkg::SPECIAL_CLKS;
        end
        if (count < ebt_pkg::MIN_CLKS) begin
            count = ebt_pkg::MIN_CLKS;
        end
    end

    // ***********************************************************
    // Sequencer and arbiter
    // ***********************************************************
    always_comb begin
        next_s = s;
        next_s.accept = 1'b0;
        next_s.flush = 1'b0;
        next_s.done = 1'b0;
        // No waiting request is granted while a write is posted or a cycle runs
        // and a wanted fetch goes first
        grant = (s.execution_unit == ebt_pkg::E_WAIT_BCU) && (s.bus_control_unit == ebt_pkg::B_IDLE) &&
                !s.wr_pend && !QUEUE_WANTS;

        unique case (s.execution_unit)
            ebt_pkg::E_IDLE: begin
                next_s.stall = 1'b0;
                if (OP_VALID && QUEUE_EMPTY) begin
                    next_s.stall = 1'b1;
                end else if (OP_VALID) begin
                    next_s.accept = 1'b1;
                    next_s.kind = OP_KIND;
                    next_s.region = rg;
                    next_s.op_addr = OP_ADDR;
                    next_s.clk_count = count;
                    next_s.len = sp_target ? ebt_pkg::SPECIAL_LEN : OP_LEN;
                    if (OP_KIND == ebt_pkg::K_BRANCH || off_main) begin
                        next_s.execution_unit = ebt_pkg::E_WAIT_BCU;
                        next_s.stall = 1'b1;
                    end else begin
                        next_s.execution_unit = ebt_pkg::E_EXEC;
                        next_s.cnt = count;
                    end
                end
            end
            ebt_pkg::E_WAIT_BCU: begin
                if (grant && s.kind == ebt_pkg::K_BRANCH) begin
                    next_s.flush = 1'b1;
                    next_s.refilled = 1'b0;
                    next_s.execution_unit = ebt_pkg::E_REFILL;
                end else if (grant) begin
                    // Reads leave here as their bus cycle starts
                    // Writes are only posted
                    next_s.execution_unit = ebt_pkg::E_EXEC;
                    next_s.stall = 1'b0;
                    next_s.cnt = s.clk_count;
                end
            end
            ebt_pkg::E_REFILL: begin
                if (s.bus_control_unit == ebt_pkg::B_FETCH && BUS_DONE) begin
                    next_s.refilled = 1'b1;
                end
                // Empty flag may lag the flush, so a finished fetch is required
                if (s.refilled && !QUEUE_EMPTY) begin
                    next_s.execution_unit = ebt_pkg::E_EXEC;
                    next_s.stall = 1'b0;
                    next_s.cnt = s.clk_count;
                end
            end
            ebt_pkg::E_EXEC: begin
                if (s.cnt <= ebt_pkg::MIN_CLKS) begin
                    next_s.done = 1'b1;
                    next_s.execution_unit = ebt_pkg::E_IDLE;
                end else begin
                    next_s.cnt = s.cnt - 16'h0001;
                end
            end
        endcase

        if (grant && (s.kind == ebt_pkg::K_WRITE || s.kind == ebt_pkg::K_SPECIAL)) begin
            next_s.wr_pend = 1'b1;
            next_s.wr_addr = s.op_addr;
        end

        unique case (s.bus_control_unit)
            ebt_pkg::B_IDLE: begin
                if (QUEUE_WANTS) begin
                    // Fetch wins over a posted write, so its start floats
                    next_s.bus_control_unit = ebt_pkg::B_FETCH;
                    next_s.bus_addr = FETCH_ADDR;
                end else if (s.wr_pend) begin
                    next_s.bus_control_unit = ebt_pkg::B_DATA;
                    next_s.bcu_wr = 1'b1;
                    next_s.bus_addr = s.wr_addr;
                    next_s.wr_pend = 1'b0;
                end else if (grant && s.kind == ebt_pkg::K_READ) begin
                    next_s.bus_control_unit = ebt_pkg::B_DATA;
                    next_s.bcu_wr = 1'b0;
                    next_s.bus_addr = s.op_addr;
                end
            end
            ebt_pkg::B_FETCH, ebt_pkg::B_DATA: begin
                if (BUS_DONE) begin
                    next_s.bus_control_unit = ebt_pkg::B_IDLE;
                    next_s.bcu_wr = 1'b0;
                end
            end
            default: begin
                next_s.bus_control_unit = ebt_pkg::B_IDLE;
            end
        endcase

        next_s.bus_fetch = (next_s.bus_control_unit == ebt_pkg::B_FETCH);
        next_s.bus_read = (next_s.bus_control_unit == ebt_pkg::B_DATA) && !next_s.bcu_wr;
        next_s.bus_write = (next_s.bus_control_unit == ebt_pkg::B_DATA) && next_s.bcu_wr;
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            s <= '0;
        end else if (CE) begin
            s <= next_s;
        end
    end

    assign OP_ACCEPT = s.accept;
    assign EXU_STALL = s.stall;
    assign QUEUE_FLUSH = s.flush;
    assign EXEC_DONE = s.done;
    assign CLK_COUNT = s.clk_count;
    assign INSTR_LEN = s.len;
    assign BUS_FETCH = s.bus_fetch;
    assign BUS_READ = s.bus_read;
    assign BUS_WRITE = s.bus_write;
    assign BUS_ADDR = s.bus_addr;
    assign WRITE_PENDING = s.wr_pend;
    assign ACCESS_REGION = s.region;

    // ***********************************************************
    // Assertions
    // ***********************************************************
    property p_empty_stall;
        @(posedge CLK) disable iff (!RSTN)
        (CE && s.execution_unit == ebt_pkg::E_IDLE && OP_VALID && QUEUE_EMPTY) |=> (s.stall && !s.accept);
    endproperty
    a_empty_stall: assert property (p_empty_stall) else $error("no stall on empty queue");

    property p_flush_refill;
        @(posedge CLK) disable iff (!RSTN)
        s.flush |-> (s.execution_unit == ebt_pkg::E_REFILL && s.stall && !s.refilled);
    endproperty
    a_flush_refill: assert property (p_flush_refill) else $error("flush without refill wait");

    property p_read_start;
        @(posedge CLK) disable iff (!RSTN)
        ($past(s.execution_unit) == ebt_pkg::E_WAIT_BCU && s.execution_unit == ebt_pkg::E_EXEC &&
         s.kind == ebt_pkg::K_READ) |-> s.bus_read;
    endproperty
    a_read_start: assert property (p_read_start) else $error("read left wait before cycle");

    property p_write_post;
        @(posedge CLK) disable iff (!RSTN)
        (CE && grant && s.kind == ebt_pkg::K_WRITE) |=> (s.execution_unit == ebt_pkg::E_EXEC && s.wr_pend);
    endproperty
    a_write_post: assert property (p_write_post) else $error("posted write held execution");

    property p_write_blocks;
        @(posedge CLK) disable iff (!RSTN)
        (CE && s.execution_unit == ebt_pkg::E_WAIT_BCU && (s.wr_pend || s.bus_write))
            |=> (s.execution_unit == ebt_pkg::E_WAIT_BCU && !s.flush);
    endproperty
    a_write_blocks: assert property (p_write_blocks) else $error("request taken during write");

    property p_fetch_first;
        @(posedge CLK) disable iff (!RSTN)
        (CE && s.bus_control_unit == ebt_pkg::B_IDLE && QUEUE_WANTS) |=> (s.bus_fetch && !s.bus_write);
    endproperty
    a_fetch_first: assert property (p_fetch_first) else $error("fetch lost arbitration");

    property p_fetch_delays;
        @(posedge CLK) disable iff (!RSTN)
        (CE && s.bus_fetch && !BUS_DONE && s.execution_unit == ebt_pkg::E_WAIT_BCU)
            |=> s.execution_unit == ebt_pkg::E_WAIT_BCU;
    endproperty
    a_fetch_delays: assert property (p_fetch_delays) else $error("request taken during fetch");

    property p_local_nostall;
        @(posedge CLK) disable iff (!RSTN)
        (CE && s.execution_unit == ebt_pkg::E_IDLE && OP_VALID && !QUEUE_EMPTY && !off_main &&
         OP_KIND != ebt_pkg::K_BRANCH) |=> (s.execution_unit == ebt_pkg::E_EXEC && !s.stall);
    endproperty
    a_local_nostall: assert property (p_local_nostall) else $error("local access stalled");

    property p_fast_window;
        @(posedge CLK) disable iff (!RSTN)
        (OP_ADDR >= ebt_pkg::FAST_RAM_LO && OP_ADDR <= ebt_pkg::FAST_RAM_HI)
            |-> rg == ebt_pkg::RG_FAST;
    endproperty
    a_fast_window: assert property (p_fast_window) else $error("fast window misclassified");

    property p_shift_count;
        @(posedge CLK) disable iff (!RSTN)
        (CE && s.execution_unit == ebt_pkg::E_IDLE && OP_VALID && !QUEUE_EMPTY &&
         OP_KIND == ebt_pkg::K_SHIFT && OP_BASE != 8'h00)
            |=> s.clk_count == $past({8'h00, OP_BASE} + {8'h00, OP_N});
    endproperty
    a_shift_count: assert property (p_shift_count) else $error("shift count wrong");

endmodule

//--- design/ebt_pkg.sv
// Constants and types shared by the execution-unit timing block.
// Assumes a single CPU clock; clock figures are in CPU clocks, SPECIAL_LEN is an instruction length.
package ebt_pkg;

    // ***********************************************************
    // Address map of data regions
    // ***********************************************************
    localparam logic [15:0] FAST_RAM_LO = 16'hFE00;
    localparam logic [15:0] FAST_RAM_HI = 16'hFEFF;
    localparam logic [15:0] PERI_RAM_LO = 16'hFC00;
    localparam logic [15:0] SFR_LO = 16'hFF00;

    // ***********************************************************
    // Clock figures
    // ***********************************************************
    localparam logic [15:0] PERI_EXTRA_HS = 16'h0003;
    localparam logic [15:0] PERI_EXTRA_NF = 16'h0002;
    localparam logic [15:0] EXT_EXTRA_HS = 16'h0001;
    localparam logic [15:0] EXT_EXTRA_NF = 16'h0000;
    localparam logic [15:0] SHIFT_PER_BIT = 16'h0001;
    localparam logic [15:0] STACK_PER_REG = 16'h0002;
    localparam logic [15:0] STRING_PER_ITER = 16'h0003;
    localparam logic [15:0] SPECIAL_CLKS = 16'h000A;
    localparam logic [15:0] MIN_CLKS = 16'h0001;
    localparam logic [2:0] SPECIAL_LEN = 3'h4;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    // ***********************************************************
    // Types
    // ***********************************************************
    typedef enum logic [1:0] {
        RG_FAST = 2'h0,
        RG_PERI = 2'h1,
        RG_SFR = 2'h2,
        RG_EXT = 2'h3
    } ebt_region_t;

    typedef enum logic [2:0] {
        K_REG = 3'h0,
        K_READ = 3'h1,
        K_WRITE = 3'h2,
        K_BRANCH = 3'h3,
        K_SHIFT = 3'h4,
        K_STACK = 3'h5,
        K_STRING = 3'h6,
        K_SPECIAL = 3'h7
    } ebt_kind_t;

    typedef enum logic [1:0] {
        E_IDLE = 2'b00,
        E_WAIT_BCU = 2'b01,
        E_REFILL = 2'b11,
        E_EXEC = 2'b10
    } ebt_exu_t;

    typedef enum logic [1:0] {
        B_IDLE = 2'b00,
        B_FETCH = 2'b01,
        B_DATA = 2'b11
    } ebt_bcu_t;

endpackage

//--- design/ebt_region.sv
// Classifies a data address into its timing region.
// Assumes a 16-bit data address; purely combinational.
module ebt_region (
    input wire logic [15:0] addr,
    output ebt_pkg::ebt_region_t region
);

    always_comb begin
        // Only the dual-port window counts as fast RAM
        if (addr >= ebt_pkg::FAST_RAM_LO && addr <= ebt_pkg::FAST_RAM_HI) begin
            region = ebt_pkg::RG_FAST;
        end else if (addr >= ebt_pkg::SFR_LO) begin
            region = ebt_pkg::RG_SFR;
        end else if (addr >= ebt_pkg::PERI_RAM_LO) begin
            region = ebt_pkg::RG_PERI;
        end else begin
            region = ebt_pkg::RG_EXT;
        end
    end

endmodule

//--- tb/ebt_bus_model.sv
// Bus and instruction queue partner for the execution timing block.
// Assumes the block's clock; answers on falling edges after a set latency.
module ebt_bus_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic bus_fetch,
    input wire logic bus_read,
    input wire logic bus_write,
    input wire logic queue_flush,
    input wire logic drain,
    input wire logic prefetch,
    input wire logic [3:0] latency,
    output logic queue_empty,
    output logic queue_wants,
    output logic [15:0] fetch_addr,
    output logic bus_done
);
    // ************************************************
    // Queue and bus cycle model
    // ************************************************
    logic need;
    logic fill;
    logic [3:0] cnt;
    assign queue_wants = need | prefetch;
    always @(negedge clk or negedge rstn) begin
        if (!rstn) begin
            {queue_empty, need, fill, bus_done} <= 4'h0;
            cnt <= 4'h0;
            fetch_addr <= 16'h0000;
        end else begin
            bus_done <= 1'b0;
            if (fill) begin
                queue_empty <= 1'b0;
                fill <= 1'b0;
            end
            if ((bus_fetch | bus_read | bus_write) && !bus_done) begin
                cnt <= cnt + 4'h1;
                if (cnt >= latency) begin
                    bus_done <= 1'b1;
                    cnt <= 4'h0;
                    // Opcodes land only after the fetch cycle ends
                    if (bus_fetch) begin
                        need <= 1'b0;
                        fill <= 1'b1;
                        fetch_addr <= fetch_addr + 16'h0002;
                    end
                end
            end
            if (queue_flush | drain) begin
                queue_empty <= 1'b1;
                need <= 1'b1;
            end
        end
    end
endmodule

//--- tb/ebt_exec_timing_tb.sv
// Self-checking bench for the execution timing block.
// Assumes the package, the block and the bus model are compiled first.
module ebt_exec_timing_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PER = 50;
    localparam bit NFO = 1'b0;
    logic clk, rstn, ce, op_valid, hs_fetch, drain, prefetch, q_empty, q_wants, bus_done;
    logic op_accept, stall, q_flush, exec_done, bus_fetch, bus_read, bus_write, w_pend;
    ebt_pkg::ebt_kind_t op_kind;
    ebt_pkg::ebt_region_t region;
    logic [15:0] op_addr, fetch_addr, clk_count, bus_addr;
    logic [7:0] op_base, op_n;
    logic [1:0] op_ext, op_tgt;
    logic [2:0] op_len, instr_len;
    logic [3:0] wait_count, latency;
    logic [31:0] rng, r;
    int fail_count, compares, k;

    ebt_exec_timing #(.NORMAL_FETCH_ONLY(NFO)) DUT (
        .CLK(clk), .RSTN(rstn), .CE(ce), .OP_VALID(op_valid), .OP_KIND(op_kind),
        .OP_ADDR(op_addr), .OP_BASE(op_base), .OP_N(op_n), .OP_EXT_ACCESSES(op_ext),
        .OP_LEN(op_len), .OP_SFR_TARGET(op_tgt), .WAIT_COUNT(wait_count),
        .HS_FETCH(hs_fetch), .QUEUE_EMPTY(q_empty), .QUEUE_WANTS(q_wants),
        .FETCH_ADDR(fetch_addr), .BUS_DONE(bus_done), .OP_ACCEPT(op_accept),
        .EXU_STALL(stall), .QUEUE_FLUSH(q_flush), .EXEC_DONE(exec_done),
        .CLK_COUNT(clk_count), .INSTR_LEN(instr_len), .BUS_FETCH(bus_fetch),
        .BUS_READ(bus_read), .BUS_WRITE(bus_write), .BUS_ADDR(bus_addr),
        .WRITE_PENDING(w_pend), .ACCESS_REGION(region)
    );
    ebt_bus_model partner (
        .clk(clk), .rstn(rstn), .bus_fetch(bus_fetch), .bus_read(bus_read),
        .bus_write(bus_write), .queue_flush(q_flush), .drain(drain), .prefetch(prefetch),
        .latency(latency), .queue_empty(q_empty), .queue_wants(q_wants),
        .fetch_addr(fetch_addr), .bus_done(bus_done)
    );

    // ************************************************
    // Expectations and helpers
    // ************************************************
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    function automatic ebt_pkg::ebt_region_t exp_region(logic [15:0] a);
        if (a >= ebt_pkg::SFR_LO) return ebt_pkg::RG_SFR;
        if (a >= ebt_pkg::FAST_RAM_LO && a <= ebt_pkg::FAST_RAM_HI) return ebt_pkg::RG_FAST;
        if (a >= ebt_pkg::PERI_RAM_LO) return ebt_pkg::RG_PERI;
        return ebt_pkg::RG_EXT;
    endfunction
    function automatic logic [15:0] exp_count();
        logic hs;
        logic [15:0] c;
        hs = hs_fetch & !NFO;
        if (op_kind == ebt_pkg::K_SPECIAL && op_tgt != 2'h0) return ebt_pkg::SPECIAL_CLKS;
        c = 16'(op_base);
        case (op_kind)
            ebt_pkg::K_SHIFT: c += 16'(op_n) * ebt_pkg::SHIFT_PER_BIT;
            ebt_pkg::K_STACK: c += 16'(op_n) * ebt_pkg::STACK_PER_REG;
            ebt_pkg::K_STRING: c += 16'(op_n) * ebt_pkg::STRING_PER_ITER;
            default: ;
        endcase
        case (exp_region(op_addr))
            ebt_pkg::RG_PERI: c += hs ? ebt_pkg::PERI_EXTRA_HS : ebt_pkg::PERI_EXTRA_NF;
            ebt_pkg::RG_EXT: c += (hs ? ebt_pkg::EXT_EXTRA_HS : ebt_pkg::EXT_EXTRA_NF)
                + 16'(wait_count) * 16'(op_ext);
            default: ;
        endcase
        return (c < ebt_pkg::MIN_CLKS) ? ebt_pkg::MIN_CLKS : c;
    endfunction
    function automatic logic sig(int w);
        case (w)
            0: return op_accept;
            1: return exec_done;
            2: return bus_fetch;
            3: return bus_read;
            default: return w_pend;
        endcase
    endfunction
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wait_for(int w);
        k = 0;
        while (sig(w) !== 1'b1 && k < 300) begin
            @(negedge clk);
            k++;
        end
        check("wait", 16'(k < 300), 16'h0001);
    endtask
    task automatic results();
        $display("Compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic run_op();
        logic [15:0] e;
        logic offm;
        e = exp_count();
        offm = exp_region(op_addr) != ebt_pkg::RG_FAST;
        op_valid = 1'b1;
        @(negedge clk);
        wait_for(0);
        op_valid = 1'b0;
        check("count", clk_count, e);
        check("length", 16'(instr_len), 16'((op_kind == ebt_pkg::K_SPECIAL &&
            op_tgt != 2'h0) ? ebt_pkg::SPECIAL_LEN : op_len));
        check("region", 16'(region), 16'(exp_region(op_addr)));
        if (op_kind != ebt_pkg::K_SPECIAL) begin
            check("stall", 16'(stall), 16'(op_kind == ebt_pkg::K_BRANCH || offm &&
                op_kind inside {ebt_pkg::K_READ, ebt_pkg::K_WRITE}));
        end
        if (op_kind == ebt_pkg::K_READ && offm) begin
            wait_for(3);
            check("read addr", bus_addr, op_addr);
            check("write left", 16'(w_pend), 16'h0000);
        end
        if (op_kind == ebt_pkg::K_BRANCH) begin
            wait_for(2);
        end
        wait_for(1);
        if (op_kind == ebt_pkg::K_BRANCH) begin
            check("refill", 16'(k > latency), 16'h0001);
        end else if (!offm && op_kind != ebt_pkg::K_SPECIAL) begin
            check("exec", 16'(k), e);
        end
    endtask

    // ************************************************
    // Clock, watchdog and bus overlap monitor
    // ************************************************
    initial begin
        clk = 1'b0;
        forever #(PER / 2) clk = ~clk;
    end
    initial begin
        #(PER * 60000);
        fail_count++;
        results();
    end
    always @(negedge clk) begin
        if (rstn === 1'b1) begin
            check("bus overlap", 16'({bus_fetch, bus_read, bus_write} inside
                {3'h0, 3'h1, 3'h2, 3'h4}), 16'h0001);
        end
    end

    // ************************************************
    // Scenarios
    // ************************************************
    initial begin
        rng = 32'h0000_529B;
        {rstn, op_valid, hs_fetch, drain, prefetch} = 5'h00;
        ce = 1'b1;
        op_kind = ebt_pkg::K_REG;
        {op_addr, op_base, op_n, op_ext, op_tgt, op_len, wait_count} = '0;
        latency = 4'h2;
        repeat (2) @(negedge clk);
        check("reset count", clk_count, 16'h0000);
        check("reset bus", 16'({op_accept, stall, bus_fetch, bus_read, w_pend}), 16'h0000);
        rstn <= 1'b1;
        @(negedge clk);
        {op_kind, op_base, op_ext, wait_count} = {ebt_pkg::K_READ, 8'h02, 2'h2, 4'hF};
        for (int i = 0; i < 6; i++) begin
            op_addr = i[0] ? 16'hFE00 + 16'(i * 127) : 16'hFBFF + 16'(i * 256);
            hs_fetch = i[1];
            run_op();
        end
        for (int j = 0; j < 4; j++) begin
            op_kind = (j < 3) ? ebt_pkg::K_SPECIAL : ebt_pkg::K_SHIFT;
            {op_addr, op_tgt, op_n, op_base} = {16'hFF10, 2'(j), 8'hFF, 8'h05};
            run_op();
        end
        latency <= 4'h8;
        drain <= 1'b1;
        @(negedge clk);
        drain <= 1'b0;
        {op_kind, op_addr, op_tgt, op_base} = {ebt_pkg::K_REG, 16'hFE10, 2'h0, 8'h02};
        op_valid = 1'b1;
        @(negedge clk);
        check("empty stall", 16'({stall, op_accept}), 16'h0002);
        run_op();
        // A low enable freezes the sequencer, so the pulse stretches and the count waits
        {op_kind, op_base} = {ebt_pkg::K_REG, 8'h04};
        r = 32'(exp_count());
        op_valid = 1'b1;
        @(negedge clk);
        wait_for(0);
        op_valid = 1'b0;
        ce = 1'b0;
        repeat (3) @(negedge clk);
        check("ce hold", 16'(op_accept), 16'h0001);
        ce = 1'b1;
        wait_for(1);
        check("ce exec", 16'(k), r[15:0]);
        {op_kind, op_addr, op_base, op_n, hs_fetch} = {ebt_pkg::K_WRITE, 16'hFD00, 8'h01, 8'h00, 1'b1};
        op_valid = 1'b1;
        @(negedge clk);
        wait_for(0);
        op_valid = 1'b0;
        wait_for(5);
        prefetch <= 1'b1;
        @(negedge clk);
        check("fetch first", 16'({bus_fetch, w_pend}), 16'h0003);
        prefetch <= 1'b0;
        wait_for(1);
        check("posted", 16'(w_pend | bus_write), 16'h0001);
        {op_kind, op_addr} = {ebt_pkg::K_READ, 16'h1234};
        run_op();
        for (int i = 0; i < 60; i++) begin
            r = xs();
            op_kind = ebt_pkg::ebt_kind_t'(r[2:0]);
            op_addr = ebt_pkg::FAST_RAM_LO | 16'(r[10:3]);
            if (op_kind inside {ebt_pkg::K_READ, ebt_pkg::K_WRITE} && r[11]) op_addr = r[31:16];
            if (op_kind == ebt_pkg::K_SPECIAL) op_addr = ebt_pkg::SFR_LO | 16'(r[10:3]);
            {op_base, op_n, op_ext, op_len, wait_count} = {4'h0, r[15:12], 5'h0, r[18:16],
                r[20:19], r[25:23], r[29:26]};
            op_tgt = (op_kind == ebt_pkg::K_SPECIAL && r[22:21] != 2'h3) ? r[22:21] : 2'h0;
            hs_fetch = r[30];
            latency <= r[31] ? 4'h8 : 4'h0;
            prefetch <= r[13] & r[14];
            @(negedge clk);
            prefetch <= 1'b0;
            run_op();
        end
        results();
    end
endmodule
